// *** src/deac_ctrl.v ***
// Data nonvolatile access controller: register file, unlock sequence,
// one-cycle reads and the self-timed erase/program cycle of one byte.
// Assumes the array returns i_nv_rdata combinationally from o_nv_addr and
// that i_warm_reset is a clocked pulse from the reset logic on i_clk.
//
// Contract
// - Memory-space bit zero selects data array
// - Config bit one routes to configuration space
// - Address is ten bits from low/high pair
// - Byte write erases then programs automatically
// - Internal timer ends each erase/write cycle
// - Writes need enable; enable clears at power-up
// - Error flag sets at start, clears on completion
// - Error flag stays after reset or improper attempt
// - Write-start set-only; hardware clears at completion
// - Done flag set on completion; software clears
// - Read-start does one-cycle read, then self-clears
// - Read-start ignored when either space bit set
// - Unlock key port stores nothing, reads zero
// - Error leaves space select bits unchanged
// - Read data valid next cycle, then held
// - Row-erase bit erases block, clears when done
// - Data register holds read or write byte
// - Write needs 55h, AAh, then write-start
// - Start needs prior enable; control, address and data frozen while busy (read-start written with write-start still reloads data)
// - Writes blocked while power-up timer runs
`timescale 1ns/100ps
`include "deac_consts.vh"
`default_nettype none

module deac_ctrl #(
   parameter [15:0] ERASE_CYC = `DEAC_ERASE_CYC,
   parameter [15:0] PROG_CYC = `DEAC_PROG_CYC
) (
   input wire i_clk,
   input wire i_reset,
   input wire i_warm_reset,
   input wire i_pwrt_running,
   input wire [2:0] i_sfr_sel,
   input wire i_sfr_wr,
   input wire i_sfr_rd,
   input wire [7:0] i_sfr_wdata,
   output reg [7:0] o_sfr_rdata,
   output wire [9:0] o_nv_addr,
   output wire [7:0] o_nv_wdata,
   output reg o_nv_read,
   input wire [7:0] i_nv_rdata,
   output reg o_nv_erase,
   output reg o_nv_program,
   output wire [1:0] o_nv_space,
   output reg o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Local states and storage.

   localparam [1:0] KEY_IDLE = 2'h0;
   localparam [1:0] KEY_FIRST = 2'h1;
   localparam [1:0] KEY_ARMED = 2'h2;

   localparam [1:0] CYC_IDLE = 2'h0;
   localparam [1:0] CYC_ERASE = 2'h1;
   localparam [1:0] CYC_PROG = 2'h2;

   reg pwrt_meta;
   reg pwrt_sync;
   reg memory_space_select;
   reg config_space_select;
   reg row_erase_enable;
   reg write_error_flag;
   reg write_unlock_enable;
   reg write_start;
   reg [7:0] nv_data_reg;
   reg [7:0] nv_addr_low;
   reg [1:0] nv_addr_high;
   reg nv_write_done_flag;
   reg nv_write_done_irq_enable;
   reg [1:0] key_state;
   reg [1:0] cyc_state;
   reg [15:0] cyc_count;

   // Counter reload for a phase of the self-timed cycle: its length in clocks minus one.
   function [15:0] deac_phase_len;
      input [1:0] phase;
      begin
         if (phase == CYC_ERASE) begin
            deac_phase_len = ERASE_CYC - 16'h0001;
         end else begin
            deac_phase_len = PROG_CYC - 16'h0001;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Decodes of the register port.

   wire wr_control = i_sfr_wr && (i_sfr_sel == `DEAC_SEL_CONTROL);
   wire wr_key = i_sfr_wr && (i_sfr_sel == `DEAC_SEL_KEY);
   // The sequencer is busy for exactly as long as write-start reads one.
   wire busy = write_start;
   wire start_req = wr_control && i_sfr_wdata[`DEAC_BIT_WR_START] && !busy;
   // A start is honoured only if enabled beforehand, armed and past power-up.
   wire start_ok = start_req && write_unlock_enable && (key_state == KEY_ARMED)
      && !pwrt_sync;
   wire data_space = !config_space_select && !memory_space_select;
   // Data bytes erase first; other spaces erase only when row erase is set.
   wire [1:0] first_phase = (data_space || row_erase_enable) ? CYC_ERASE : CYC_PROG;
   wire phase_end = (cyc_state != CYC_IDLE) && (cyc_count == 16'h0000);
   wire last_phase = (cyc_state == CYC_PROG) || !data_space;
   wire cyc_finish = phase_end && last_phase;
   wire [7:0] control_view = {memory_space_select, config_space_select, 1'b0,
      row_erase_enable, write_error_flag, write_unlock_enable, write_start, o_nv_read};

   assign o_nv_addr = {nv_addr_high, nv_addr_low};
   assign o_nv_wdata = nv_data_reg;
   assign o_nv_space = {config_space_select, memory_space_select};

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchroniser for the power-up timer pin.
   // Both flops reset to one, so writes stay blocked until a low on the pin
   // has passed through both flops and no write can slip through just after power-up.

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pwrt_meta <= 1'b1;
         pwrt_sync <= 1'b1;
      end else begin
         pwrt_meta <= i_pwrt_running;
         pwrt_sync <= pwrt_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Unlock sequence: 55h then AAh on the key port, then write-start as the
   // very next register write. Any other write breaks the sequence.

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         key_state <= KEY_IDLE;
      end else if (i_warm_reset) begin
         key_state <= KEY_IDLE;
      end else if (wr_key) begin
         if (i_sfr_wdata == `DEAC_KEY_FIRST) begin
            key_state <= KEY_FIRST;
         end else if (i_sfr_wdata == `DEAC_KEY_SECOND && key_state == KEY_FIRST) begin
            key_state <= KEY_ARMED;
         end else begin
            key_state <= KEY_IDLE;
         end
      end else if (i_sfr_wr) begin
         key_state <= KEY_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register, erase/program sequencer and write-done flag.

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         memory_space_select <= 1'b0;
         config_space_select <= 1'b0;
         row_erase_enable <= 1'b0;
         write_error_flag <= 1'b0;
         write_unlock_enable <= 1'b0;
         write_start <= 1'b0;
         o_nv_read <= 1'b0;
         nv_data_reg <= `DEAC_RST_BYTE;
         nv_addr_low <= `DEAC_RST_BYTE;
         nv_addr_high <= `DEAC_RST_ADDR_HIGH;
         nv_write_done_flag <= 1'b0;
         nv_write_done_irq_enable <= 1'b0;
         cyc_state <= CYC_IDLE;
         cyc_count <= 16'h0000;
         o_nv_erase <= 1'b0;
         o_nv_program <= 1'b0;
      end else if (i_warm_reset) begin
         // A reset mid-cycle aborts it and leaves the error flag standing.
         // Address, data and space bits survive so software can see what failed.
         if (busy) begin
            write_error_flag <= 1'b1;
         end
         write_unlock_enable <= 1'b0;
         write_start <= 1'b0;
         o_nv_read <= 1'b0;
         cyc_state <= CYC_IDLE;
         o_nv_erase <= 1'b0;
         o_nv_program <= 1'b0;
      end else begin
         // Software writes; control, address and data freeze while busy.
         if (wr_control && !busy) begin
            memory_space_select <= i_sfr_wdata[`DEAC_BIT_MEM_SPACE];
            config_space_select <= i_sfr_wdata[`DEAC_BIT_CFG_SPACE];
            row_erase_enable <= i_sfr_wdata[`DEAC_BIT_ROW_ERASE];
            write_error_flag <= i_sfr_wdata[`DEAC_BIT_WR_ERROR];
            write_unlock_enable <= i_sfr_wdata[`DEAC_BIT_WR_ENABLE];
            // Read-start is set-only and refused outside the data array.
            if (i_sfr_wdata[`DEAC_BIT_RD_START] && !i_sfr_wdata[`DEAC_BIT_MEM_SPACE]
               && !i_sfr_wdata[`DEAC_BIT_CFG_SPACE]) begin
               o_nv_read <= 1'b1;
            end
         end
         if (i_sfr_wr && !busy && i_sfr_sel == `DEAC_SEL_DATA) begin
            nv_data_reg <= i_sfr_wdata;
         end
         if (i_sfr_wr && !busy && i_sfr_sel == `DEAC_SEL_ADDR_LOW) begin
            nv_addr_low <= i_sfr_wdata;
         end
         if (i_sfr_wr && !busy && i_sfr_sel == `DEAC_SEL_ADDR_HIGH) begin
            nv_addr_high <= i_sfr_wdata[1:0];
         end
         if (i_sfr_wr && i_sfr_sel == `DEAC_SEL_FLAG2) begin
            nv_write_done_flag <= i_sfr_wdata[`DEAC_BIT_DONE];
         end
         if (i_sfr_wr && i_sfr_sel == `DEAC_SEL_IRQ_EN2) begin
            nv_write_done_irq_enable <= i_sfr_wdata[`DEAC_BIT_DONE];
         end

         // One-cycle array read: capture the byte and clear read-start.
         if (o_nv_read) begin
            nv_data_reg <= i_nv_rdata;
            o_nv_read <= 1'b0;
         end

         // Write-start: a clean start launches the cycle, anything else
         // only marks an improper attempt. Writes of zero do nothing.
         if (start_ok) begin
            write_start <= 1'b1;
            write_error_flag <= 1'b1;
            cyc_state <= first_phase;
            cyc_count <= deac_phase_len(first_phase);
            o_nv_erase <= (first_phase == CYC_ERASE);
            o_nv_program <= (first_phase == CYC_PROG);
         end else if (start_req) begin
            write_error_flag <= 1'b1;
         end

         // Internal timer paces each phase of the self-timed cycle.
         if (cyc_state != CYC_IDLE && cyc_count != 16'h0000) begin
            cyc_count <= cyc_count - 16'h0001;
         end
         if (phase_end && !last_phase) begin
            cyc_state <= CYC_PROG;
            cyc_count <= deac_phase_len(CYC_PROG);
            o_nv_erase <= 1'b0;
            o_nv_program <= 1'b1;
         end
         // Completion: hardware clears write-start, error and row erase;
         // the done flag set here wins over a same-cycle software clear.
         if (cyc_finish) begin
            cyc_state <= CYC_IDLE;
            write_start <= 1'b0;
            write_error_flag <= 1'b0;
            row_erase_enable <= 1'b0;
            nv_write_done_flag <= 1'b1;
            o_nv_erase <= 1'b0;
            o_nv_program <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request follows the done flag gated by its enable.
   // Flag and enable are both visible to software; only their product
   // leaves the block, one clock after either changes.

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= nv_write_done_flag && nv_write_done_irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read port; the key port and unmapped selects read zero.
   // Reads are registered, so o_sfr_rdata changes only after a read strobe.

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         if (i_sfr_sel == `DEAC_SEL_CONTROL) begin
            o_sfr_rdata <= control_view;
         end else if (i_sfr_sel == `DEAC_SEL_DATA) begin
            o_sfr_rdata <= nv_data_reg;
         end else if (i_sfr_sel == `DEAC_SEL_ADDR_LOW) begin
            o_sfr_rdata <= nv_addr_low;
         end else if (i_sfr_sel == `DEAC_SEL_ADDR_HIGH) begin
            o_sfr_rdata <= {6'h00, nv_addr_high};
         end else if (i_sfr_sel == `DEAC_SEL_FLAG2) begin
            o_sfr_rdata <= {3'h0, nv_write_done_flag, 4'h0};
         end else if (i_sfr_sel == `DEAC_SEL_IRQ_EN2) begin
            o_sfr_rdata <= {3'h0, nv_write_done_irq_enable, 4'h0};
         end else begin
            o_sfr_rdata <= 8'h00;
         end
      end
   end

endmodule

`default_nettype wire

// *** include/deac_consts.vh ***
// Constants for the data nonvolatile access controller: register selects,
// control field positions, unlock key values, reset values and cycle timing.
// Assumes a 50 MHz instruction clock and a 3-bit register select port.
`ifndef DEAC_CONSTS_VH
`define DEAC_CONSTS_VH

// Register selects on the register port.
`define DEAC_SEL_CONTROL 3'h0
`define DEAC_SEL_KEY 3'h1
`define DEAC_SEL_DATA 3'h2
`define DEAC_SEL_ADDR_LOW 3'h3
`define DEAC_SEL_ADDR_HIGH 3'h4
`define DEAC_SEL_FLAG2 3'h5
`define DEAC_SEL_IRQ_EN2 3'h6

// Field positions in nv_access_control.
`define DEAC_BIT_MEM_SPACE 7
`define DEAC_BIT_CFG_SPACE 6
`define DEAC_BIT_ROW_ERASE 4
`define DEAC_BIT_WR_ERROR 3
`define DEAC_BIT_WR_ENABLE 2
`define DEAC_BIT_WR_START 1
`define DEAC_BIT_RD_START 0

// Field position of the write-done flag and its enable.
`define DEAC_BIT_DONE 4

// Unlock key values.
`define DEAC_KEY_FIRST 8'h55
`define DEAC_KEY_SECOND 8'hAA

// Reset values.
`define DEAC_RST_BYTE 8'h00
`define DEAC_RST_ADDR_HIGH 2'h0

// Self-timed cycle: times in ns, counts rounded up to whole clocks.
`define DEAC_CLK_NS 20
`define DEAC_ERASE_NS 2000
`define DEAC_PROG_NS 2000
`define DEAC_ERASE_CYC ((`DEAC_ERASE_NS + `DEAC_CLK_NS - 1) / `DEAC_CLK_NS)
`define DEAC_PROG_CYC ((`DEAC_PROG_NS + `DEAC_CLK_NS - 1) / `DEAC_CLK_NS)

`endif

// *** test/deac_ctrl_assertions.sv ***
// Checker for deac_ctrl: read pulse, phase lengths and register freezing.
// Assumes it is bound to every deac_ctrl instance by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
`include "deac_consts.vh"
module deac_ctrl_assertions #(
   parameter [15:0] ERASE_CYC = `DEAC_ERASE_CYC,
   parameter [15:0] PROG_CYC = `DEAC_PROG_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_warm_reset,
   input wire logic i_pwrt_running,
   input wire logic [2:0] i_sfr_sel,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic [9:0] o_nv_addr,
   input wire logic [7:0] o_nv_wdata,
   input wire logic o_nv_read,
   input wire logic [7:0] i_nv_rdata,
   input wire logic o_nv_erase,
   input wire logic o_nv_program,
   input wire logic [1:0] o_nv_space,
   input wire logic o_irq
);
   reg [15:0] ecnt;
   reg [15:0] pcnt;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////
   // Count the cycles each phase has stood so far.
   always @(posedge i_clk) begin
      ecnt <= o_nv_erase ? ecnt + 16'h0001 : 16'h0000;
      pcnt <= o_nv_program ? pcnt + 16'h0001 : 16'h0000;
   end
   a_read_single: assert property (o_nv_read |=> !o_nv_read)
      else $error("array read longer than one cycle");
   a_read_space: assert property (o_nv_read |-> o_nv_space == 2'h0)
      else $error("array read outside data space");
   a_read_loads: assert property (o_nv_read && !(i_sfr_wr && i_sfr_sel == `DEAC_SEL_DATA)
      |=> o_nv_wdata == $past(i_nv_rdata)) else $error("read byte not loaded");
   a_erase_program: assert property ($fell(o_nv_erase) && o_nv_space == 2'h0
      && !$past(i_warm_reset) && !$past(i_warm_reset, 2) |-> o_nv_program)
      else $error("erase not followed by program");
   a_erase_length: assert property ($fell(o_nv_erase) && o_nv_program
      |-> ecnt == ERASE_CYC) else $error("erase phase length wrong");
   a_prog_length: assert property ($fell(o_nv_program) && !$past(i_warm_reset)
      && !$past(i_warm_reset, 2) |-> pcnt == PROG_CYC) else $error("program length wrong");
   a_regs_frozen: assert property (o_nv_erase || o_nv_program |=> $stable(o_nv_addr)
      && $stable(o_nv_wdata) && $stable(o_nv_space)) else $error("registers moved in cycle");
   a_key_zero: assert property (i_sfr_rd && i_sfr_sel == `DEAC_SEL_KEY
      |=> o_sfr_rdata == 8'h00) else $error("key port read not zero");
endmodule
bind deac_ctrl deac_ctrl_assertions #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) u_chk (
   .i_clk(i_clk), .i_reset(i_reset), .i_warm_reset(i_warm_reset),
   .i_pwrt_running(i_pwrt_running), .i_sfr_sel(i_sfr_sel), .i_sfr_wr(i_sfr_wr),
   .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
   .o_nv_addr(o_nv_addr), .o_nv_wdata(o_nv_wdata), .o_nv_read(o_nv_read),
   .i_nv_rdata(i_nv_rdata), .o_nv_erase(o_nv_erase), .o_nv_program(o_nv_program),
   .o_nv_space(o_nv_space), .o_irq(o_irq));
`default_nettype wire

// *** test/deac_nv_model.sv ***
// Behavioural byte array on the far side of deac_ctrl.
// Assumes erase and program are levels held for a whole phase.
`timescale 1ns/100ps
`default_nettype none
module deac_nv_model (
   input wire logic i_clk,
   input wire logic [9:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_erase,
   input wire logic i_program,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:1023];
   ////////////////////////////////////////////////////////////
   // A preload unlike the written data exposes a skipped erase.
   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = i[7:0] ^ 8'h5A;
      end
   end
   // Erase sets every bit; programming can only clear bits.
   always @(posedge i_clk) begin
      if (i_erase) begin
         mem[i_addr] <= 8'hFF;
      end else if (i_program) begin
         mem[i_addr] <= mem[i_addr] & i_wdata;
      end
   end
   assign o_rdata = mem[i_addr]; // Combinational read, as the controller expects.
endmodule
`default_nettype wire

// *** test/deac_ctrl_test.sv ***
// Self-checking bench for deac_ctrl with a behavioural array beside it.
// Assumes the register selects and field layout of deac_consts.vh.
`timescale 1ns/100ps
`default_nettype none
`include "deac_consts.vh"
module deac_ctrl_test;
   logic clk, rst, wrst, pwrt, wr, rd, nrd, ers, prg, irq;
   logic [2:0] sel;
   logic [7:0] wd, rdat, nwd, ard;
   logic [9:0] addr;
   logic [1:0] spc;
   int mismatches = 0;
   int samples_checked = 0;
   // Short phases keep each write cycle to ten clocks.
   deac_ctrl #(.ERASE_CYC(16'h0006), .PROG_CYC(16'h0004)) uut (.i_clk(clk), .i_reset(rst),
      .i_warm_reset(wrst), .i_pwrt_running(pwrt), .i_sfr_sel(sel), .i_sfr_wr(wr),
      .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdat), .o_nv_addr(addr),
      .o_nv_wdata(nwd), .o_nv_read(nrd), .i_nv_rdata(ard), .o_nv_erase(ers),
      .o_nv_program(prg), .o_nv_space(spc), .o_irq(irq));
   deac_nv_model nv (.i_clk(clk), .i_addr(addr), .i_wdata(nwd), .i_erase(ers),
      .i_program(prg), .o_rdata(ard));
   ////////////////////////////////////////////////////////////
   // A 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task finish_test;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input logic [9:0] g, input logic [9:0] e);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr_reg(input logic [2:0] s, input logic [7:0] d);
      @(posedge clk);
      sel <= s;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [2:0] s, input logic [7:0] e);
      @(posedge clk);
      sel <= s;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdat, e);
   endtask
   // Unlock with a chosen second key, then write the control byte.
   task start(input logic [7:0] k, input logic [7:0] c);
      wr_reg(`DEAC_SEL_KEY, 8'h55);
      wr_reg(`DEAC_SEL_KEY, k);
      wr_reg(`DEAC_SEL_CONTROL, c);
   endtask
   task wait_idle;
      int n;
      n = 0;
      @(negedge clk);
      while ((ers || prg) && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (n == 300) begin
         mismatches++;
         finish_test;
      end
   endtask
   task t_reset_vals;
      rd_chk(`DEAC_SEL_CONTROL, 8'h00);
      rd_chk(`DEAC_SEL_KEY, 8'h00);
      rd_chk(3'h7, 8'h00);
      chk(spc, 2'h0);
   endtask
   // Full byte write, frozen data, done flag, interrupt and read back.
   task t_write(input logic [9:0] a, input logic [7:0] d);
      wr_reg(`DEAC_SEL_ADDR_LOW, a[7:0]);
      wr_reg(`DEAC_SEL_ADDR_HIGH, {6'h3F, a[9:8]});
      wr_reg(`DEAC_SEL_DATA, d);
      wr_reg(`DEAC_SEL_CONTROL, 8'h04);
      wr_reg(`DEAC_SEL_IRQ_EN2, 8'h10);
      chk(addr, a);
      rd_chk(`DEAC_SEL_ADDR_LOW, a[7:0]);
      rd_chk(`DEAC_SEL_ADDR_HIGH, {6'h00, a[9:8]});
      rd_chk(`DEAC_SEL_IRQ_EN2, 8'h10);
      start(8'hAA, 8'h06);
      rd_chk(`DEAC_SEL_CONTROL, 8'h0E);
      wr_reg(`DEAC_SEL_DATA, 8'h00);
      chk(nwd, d);
      wait_idle;
      rd_chk(`DEAC_SEL_CONTROL, 8'h04);
      chk(irq, 1'b1);
      rd_chk(`DEAC_SEL_FLAG2, 8'h10);
      wr_reg(`DEAC_SEL_FLAG2, 8'h00);
      rd_chk(`DEAC_SEL_FLAG2, 8'h00);
      chk(irq, 1'b0);
      wr_reg(`DEAC_SEL_DATA, 8'h00);
      wr_reg(`DEAC_SEL_CONTROL, 8'h05);
      rd_chk(`DEAC_SEL_DATA, d);
      rd_chk(`DEAC_SEL_CONTROL, 8'h04);
   endtask
   // Wrong key, enable in the same write, power-up timer, refused reads.
   task t_refused;
      wr_reg(`DEAC_SEL_CONTROL, 8'h04);
      start(8'hAB, 8'h06);
      rd_chk(`DEAC_SEL_CONTROL, 8'h0C);
      chk(ers | prg, 1'b0);
      wr_reg(`DEAC_SEL_CONTROL, 8'h00);
      start(8'hAA, 8'h06);
      rd_chk(`DEAC_SEL_CONTROL, 8'h0C);
      chk(ers | prg, 1'b0);
      @(posedge clk);
      pwrt <= 1'b1;
      start(8'hAA, 8'h06);
      rd_chk(`DEAC_SEL_CONTROL, 8'h0C);
      chk(ers | prg, 1'b0);
      @(posedge clk);
      pwrt <= 1'b0;
      wr_reg(`DEAC_SEL_CONTROL, 8'h81);
      rd_chk(`DEAC_SEL_CONTROL, 8'h80);
      chk(spc, 2'h1);
      wr_reg(`DEAC_SEL_CONTROL, 8'h41);
      rd_chk(`DEAC_SEL_CONTROL, 8'h40);
      chk(spc, 2'h2);
   endtask
   // Row erase in program space, then a warm reset in mid-cycle.
   task t_erase_abort;
      wr_reg(`DEAC_SEL_CONTROL, 8'h94);
      start(8'hAA, 8'h96);
      rd_chk(`DEAC_SEL_CONTROL, 8'h9E);
      wait_idle;
      rd_chk(`DEAC_SEL_CONTROL, 8'h84);
      start(8'hAA, 8'h86);
      @(posedge clk);
      wrst <= 1'b1;
      @(posedge clk);
      wrst <= 1'b0;
      wait_idle;
      rd_chk(`DEAC_SEL_CONTROL, 8'h88);
   endtask
   initial begin
      rst = 1'b1;
      wrst = 1'b0;
      pwrt = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      sel = 3'h0;
      wd = 8'h00;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset_vals;
      t_write(10'h3FF, 8'h5A);
      t_write(10'h155, 8'hF0);
      t_refused;
      t_erase_abort;
      finish_test;
   end
endmodule
`default_nettype wire
